// >>> sdss_spinup.sv
// strap capture, start-up policy decode and staggered motor spin-up
`timescale 1ns/1ps

// What this block does
// [RULE_01] four strap bits form binary target identifier
// [RULE_02] installed jumper reads as logic one
// [RULE_03] auto mode spins up without start command
// [RULE_04] otherwise stay stopped, not ready, until start
// [RULE_05] auto delay equals multiplier seconds times identifier
// [RULE_06] decode table for the 68-pin variant
// [RULE_07] decode table for the 80-pin variant
// [RULE_08] integrator uses front block or auxiliary, never both
// [RULE_09] auxiliary auto spin input: grounded means enabled; on the 80-pin variant it acts as the start strap, so auto is disabled
// [RULE_10] external driver is open collector, floats released
// [RULE_11] external fault input is ignored entirely
// [RULE_12] straps sampled once after reset, then held
module sdss_spinup
  import sdss_pkg::*;
#(
  parameter int unsigned SEC_COUNT = SEC_CYCLES  // cycles per second, shorten in simulation
) (
  input  wire logic            sys_clk,              // 200 MHz clock
  input  wire logic            resetn,               // power-on reset, active low
  input  wire logic            variant_80,           // 1: 80-pin variant, 0: 68-pin
  input  wire logic [ID_W-1:0] id_jumper,            // id straps, 1 = jumper installed
  input  wire logic            start_jumper,         // auto start strap, 1 = installed
  input  wire logic            delay_jumper,         // auto start delay strap, 1 = installed
  input  wire logic            aux_spin_start_n,     // auxiliary auto spin, 0 = grounded
  input  wire logic            external_fault_input, // auxiliary fault line, unused
  input  wire logic            start_unit,           // one-cycle start-unit command pulse
  output logic [ID_W-1:0]      target_id,            // decoded target identifier
  output logic                 auto_start,           // auto start-up mode selected
  output logic [MULT_W-1:0]    delay_mult,           // delay multiplier in seconds
  output logic                 motor_on,             // spin-up command to motor
  output logic                 unit_ready            // ready for media access
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    sdss_state_t       st;
    logic [ID_W-1:0]   id;
    logic              auto_en;
    logic [MULT_W-1:0] mult;
    logic [SECS_W-1:0] secs;   // whole seconds still to wait
    logic [31:0]       tick;   // cycles within the current second
    logic              motor;
  } sdss_regs_t;

  sdss_regs_t r_q;
  sdss_regs_t r_d;

  // decoded policy: {auto, multiplier}; a grounded auxiliary line acts as the start strap
  function automatic logic [MULT_W:0] decode_policy(input logic is80, input logic st,
                                                    input logic dl);
    logic [MULT_W:0] res;
    res = {1'b0, MULT_NONE};
    if (is80) begin
      if (!st) res = {1'b1, dl ? MULT_LONG : MULT_NONE}; // RULE_07
    end else begin
      unique case ({dl, st})                               // RULE_06
        2'b01:   res = {1'b1, MULT_NONE};
        2'b10:   res = {1'b1, MULT_LONG};
        2'b11:   res = {1'b1, MULT_MID};
        default: res = {1'b0, MULT_NONE};
      endcase
    end
    return res;
  endfunction

  // stagger in whole seconds; operands widened first so 10 x 15 cannot wrap
  function automatic logic [SECS_W-1:0] stagger_secs(input logic [MULT_W-1:0] m,
                                                     input logic [ID_W-1:0]   id);
    return SECS_W'(m) * SECS_W'(id);
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  // the fault line is deliberately never read; nothing depends on it  // RULE_11
  always_comb begin
    logic [MULT_W:0] pol;
    logic            st_eff;
    st_eff = start_jumper | ~aux_spin_start_n;                   // RULE_02 RULE_09
    pol    = decode_policy(variant_80, st_eff, delay_jumper);
    r_d    = r_q;
    unique case (r_q.st)
      SDSS_CAPTURE: begin
        // one-shot capture at first edge after release, held until next reset
        r_d.id      = id_jumper;                                 // RULE_01 RULE_12
        r_d.auto_en = pol[MULT_W];
        r_d.mult    = pol[MULT_W-1:0];
        r_d.secs    = stagger_secs(pol[MULT_W-1:0], id_jumper);  // RULE_05
        r_d.tick    = '0;
        r_d.st      = pol[MULT_W] ? SDSS_WAIT : SDSS_IDLE;       // RULE_03 RULE_04
      end
      SDSS_WAIT: begin
        if (r_q.secs == SECS_RST) begin
          r_d.st    = SDSS_SPIN;                                 // RULE_03
          r_d.motor = 1'b1;
        end else if (r_q.tick == SEC_COUNT - 1) begin
          r_d.tick = '0;
          r_d.secs = r_q.secs - 8'h01;                           // RULE_05
        end else begin
          r_d.tick = r_q.tick + 32'h0000_0001;
        end
      end
      SDSS_IDLE: begin
        // motor held off until the initiator asks
        if (start_unit) begin                                    // RULE_04
          r_d.st    = SDSS_SPIN;
          r_d.motor = 1'b1;
        end
      end
      SDSS_SPIN: r_d = r_q;
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      r_q <= '{st: SDSS_CAPTURE, id: ID_RST, auto_en: 1'b0, mult: MULT_NONE,
               secs: SECS_RST, tick: 32'h0000_0000, motor: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from the state flops
  assign target_id  = r_q.id;
  assign auto_start = r_q.auto_en;
  assign delay_mult = r_q.mult;
  assign motor_on   = r_q.motor;
  assign unit_ready = r_q.motor;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_idle_start;
    (r_q.st == SDSS_IDLE) && start_unit;
  endsequence

  // the capture edge itself; sampled resetn keeps the release edge out
  sequence s_capture;
    resetn && (r_q.st == SDSS_CAPTURE);
  endsequence

  // two cycles past capture, so the capture update is not taken for a change
  sequence s_settled;
    (r_q.st != SDSS_CAPTURE) ##1 (r_q.st != SDSS_CAPTURE);
  endsequence

  chk_id_held: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_12
    s_settled |-> $stable(target_id))
    else $error("target id changed after capture");

  chk_policy_held: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_12
    s_settled |-> $stable(auto_start) && $stable(delay_mult))
    else $error("start-up policy changed after capture");

  chk_id_capture: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_01
    s_capture |=> (target_id == $past(id_jumper)))
    else $error("target id not captured from straps");

  chk_manual_stop: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_04
    (!auto_start && r_q.st == SDSS_IDLE) |-> !motor_on && !unit_ready)
    else $error("motor running without start command");

  chk_idle_manual: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_04
    (r_q.st == SDSS_IDLE) |-> !auto_start)
    else $error("waiting for start command in auto mode");

  chk_start_cmd: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_04
    s_idle_start |=> motor_on)
    else $error("start command did not spin motor");

  chk_spin_holds: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_03 RULE_04
    motor_on |=> motor_on && unit_ready)
    else $error("motor or ready dropped while spinning");

  chk_auto_zero: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_03
    (r_q.st == SDSS_WAIT && r_q.secs == SECS_RST) |=> motor_on)
    else $error("auto start did not spin up");

  chk_wait_auto: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_03
    (r_q.st == SDSS_WAIT) |-> auto_start && !motor_on)
    else $error("stagger wait outside auto mode");

  chk_no_early: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_05
    (r_q.st == SDSS_WAIT && r_q.secs != SECS_RST) |=> !motor_on)
    else $error("motor started before delay elapsed");

  chk_sec_step: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_05
    (r_q.st == SDSS_WAIT && r_q.secs != SECS_RST && r_q.tick == SEC_COUNT - 1)
      |=> r_q.secs == $past(r_q.secs) - 8'h01)
    else $error("second count did not step once per second");

  chk_secs_load: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_05
    (r_q.st == SDSS_WAIT && $past(r_q.st) == SDSS_CAPTURE)
      |-> r_q.secs == stagger_secs(delay_mult, target_id))
    else $error("delay not multiplier times id");

  chk_decode_68: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_06
    (s_capture ##0 (!variant_80 && delay_jumper && start_jumper))
      |=> auto_start && delay_mult == MULT_MID)
    else $error("68-pin both straps decode wrong");

  chk_decode_off: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_06
    (s_capture ##0 (!variant_80 && !delay_jumper && !start_jumper && aux_spin_start_n))
      |=> !auto_start)
    else $error("68-pin no straps must leave auto off");

  chk_decode_80: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_07
    (s_capture ##0 (variant_80 && start_jumper)) |=> !auto_start)
    else $error("80-pin start strap must disable auto");

  chk_decode_zero: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_07
    (s_capture ##0 (variant_80 && !delay_jumper && !start_jumper && aux_spin_start_n))
      |=> auto_start && delay_mult == MULT_NONE)
    else $error("80-pin no straps must auto start at once");

  chk_decode_long: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_06 RULE_07
    (s_capture ##0 (delay_jumper && !start_jumper && aux_spin_start_n))
      |=> auto_start && delay_mult == MULT_LONG)
    else $error("delay strap alone must give ten seconds");

  chk_aux_ground: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_09
    (s_capture ##0 (!variant_80 && !aux_spin_start_n)) |=> auto_start)
    else $error("grounded auxiliary line must enable auto");

endmodule

// >>> sdss_pkg.sv
// shared constants and types for the strap decode and spin-up stagger block
package sdss_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 200_000_000;  // sys_clk rate
  localparam int unsigned SEC_NS        = 1_000_000_000; // one second in ns
  localparam int unsigned CLK_PERIOD_NS = SEC_NS / CLK_HZ;
  localparam int unsigned SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS; // cycles per second

  // ****************************************************************
  // widths and decode values
  // ****************************************************************
  localparam int unsigned ID_W   = 4;   // target identifier width
  localparam int unsigned MULT_W = 4;   // delay multiplier width
  localparam int unsigned SECS_W = 8;   // multiplier times identifier, max 150
  localparam logic [MULT_W-1:0] MULT_NONE = 4'h0;
  localparam logic [MULT_W-1:0] MULT_LONG = 4'hA;  // ten seconds
  localparam logic [MULT_W-1:0] MULT_MID  = 4'h4;  // four seconds
  localparam logic [ID_W-1:0]   ID_RST    = 4'h0;
  localparam logic [SECS_W-1:0] SECS_RST  = 8'h00;

  typedef enum logic [1:0] {
    SDSS_CAPTURE,
    SDSS_WAIT,
    SDSS_SPIN,
    SDSS_IDLE
  } sdss_state_t;

endpackage

// >>> sdss_strap_model.sv
// integrator strap model: front option block or auxiliary line, never both
`timescale 1ns/1ps
module sdss_strap_model
  import sdss_pkg::*;
(
  input  wire logic [ID_W-1:0] cfg_id,           // identifier the integrator wants
  input  wire logic            cfg_st,           // start strap wanted
  input  wire logic            cfg_aux,          // use auxiliary line for the start strap
  output logic [ID_W-1:0]      id_jumper,        // installed jumper reads one
  output logic                 start_jumper,     // front start strap
  output logic                 aux_spin_start_n  // auxiliary open-collector line
);
  // jumpers map straight to strap levels
  assign id_jumper        = cfg_id;
  // the start request goes to exactly one source
  assign start_jumper     = cfg_st & ~cfg_aux;
  // a released open-collector line floats up to the pull-up level
  assign aux_spin_start_n = ~(cfg_st & cfg_aux);
endmodule

// >>> tb.sv
// self-checking bench for strap decode and staggered spin-up
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
module tb;
  import sdss_pkg::*;
  localparam int SEC = 4;              // short second keeps the run brief
  logic sys_clk = 1'b0, resetn = 1'b0, variant_80 = 1'b0, cfg_st = 1'b0, cfg_dl = 1'b0;
  logic cfg_aux = 1'b0, fault = 1'b0, start_unit = 1'b0;
  logic [ID_W-1:0] cfg_id = 4'h0, id_jumper, target_id;
  logic start_jumper, aux_spin_start_n, auto_start, motor_on, unit_ready;
  logic [MULT_W-1:0] delay_mult;
  logic [7:0] lfsr = 8'h5B;            // seed 91
  int errors = 0, n_tests = 0;
  // ****************************************************************
  // design and integrator model
  // ****************************************************************
  sdss_strap_model i_straps (.cfg_id(cfg_id), .cfg_st(cfg_st), .cfg_aux(cfg_aux),
    .id_jumper(id_jumper), .start_jumper(start_jumper), .aux_spin_start_n(aux_spin_start_n));
  sdss_spinup #(.SEC_COUNT(SEC)) i_dut (.sys_clk(sys_clk), .resetn(resetn),
    .variant_80(variant_80), .id_jumper(id_jumper), .start_jumper(start_jumper),
    .delay_jumper(cfg_dl), .aux_spin_start_n(aux_spin_start_n),
    .external_fault_input(fault), .start_unit(start_unit), .target_id(target_id),
    .auto_start(auto_start), .delay_mult(delay_mult), .motor_on(motor_on),
    .unit_ready(unit_ready));
  // free-running 200 MHz clock
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic [7:0] nxt(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  // expected {auto_start, delay_mult}; a stopped policy reports no multiplier
  function automatic logic [4:0] exp_dec(input logic v, input logic s, input logic d);
    if (v) return s ? 5'h00 : {1'b1, d ? MULT_LONG : MULT_NONE};
    if (!s && !d) return 5'h00;
    return {1'b1, d ? (s ? MULT_MID : MULT_LONG) : MULT_NONE};
  endfunction
  task automatic complete_run();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one power-on with a given strap set; straps flip after capture to prove they are held
  task automatic run_case(input logic [3:0] c, input logic [ID_W-1:0] id);
    logic [4:0] e;
    int on_k, secs;
    on_k = 0;
    e = exp_dec(c[3], c[2], c[1]);
    secs = int'(e[3:0]) * int'(id);
    @(posedge sys_clk);
    resetn <= 1'b0; variant_80 <= c[3]; cfg_st <= c[2]; cfg_dl <= c[1]; cfg_aux <= c[0];
    cfg_id <= id;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int k = 1; k <= 720; k++) begin
      @(posedge sys_clk);
      if (k == 3) begin
        cfg_id <= ~id; variant_80 <= ~c[3]; cfg_dl <= ~c[1]; fault <= ~fault;
        cfg_st <= ~c[2]; cfg_aux <= ~c[0];
      end
      if (k == 700) start_unit <= 1'b1;
      if (k == 701) start_unit <= 1'b0;
      #1;
      if (k == 2) `CHK(target_id, id)
      if (k == 2) `CHK({auto_start, delay_mult}, e)
      if (k == 699 && !e[4]) `CHK(unit_ready, 1'b0)
      if (motor_on === 1'b1 && on_k == 0) on_k = k;
    end
    `CHK(target_id, id)
    `CHK({auto_start, delay_mult}, e)
    `CHK(unit_ready, 1'b1)
    if (e[4]) `CHK(on_k, secs * SEC + 2)
    else `CHK(on_k, 701)
    if (e[4]) `CHK(on_k < 700, 1'b1)
    $display("case %0h id %0h spin-up at cycle %0d", c, id, on_k);
  endtask
  // ****************************************************************
  // every strap combination, both variants, both start sources
  // ****************************************************************
  initial begin
    for (int c = 0; c < 16; c++) begin
      lfsr = nxt(lfsr);
      fault <= lfsr[7];
      run_case(4'(c), (c == 0) ? 4'h0 : (c == 2 || c == 15) ? 4'hF : lfsr[3:0]);
    end
    complete_run();
  end
  // watchdog well beyond sixteen cases of about 730 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    complete_run();
  end
endmodule
